// ### dcp_pwm.sv
`timescale 1ns/10ps
// ==========================================================================
// dual channel pwm unit with an avalon-mm register slave
// ==========================================================================
// Behaviour
// - The shared counter advances only on ticks of an 8-bit prescaler.
// - One prescaler and one counter serve both channels.
// - The counter steps 0 to 254 and wraps to 0, a period of 255 ticks.
// - A channel is low while its width is greater than the counter.
// - A channel is high while its width is equal to or below the counter.
// - A new width acts on the compare at once, not at period end.
// - The prescaler divides by its reload value plus one.
// - Reading the prescaler register returns the reload, not the count.
// - A fixed divide by two stands ahead of the prescaler.
// - Duty runs 0/255 to 255/255 in steps of one count.
module dcp_pwm #(
   parameter int unsigned NUM_CH = dcp_pkg::CH_COUNT
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic [dcp_pkg::ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [dcp_pkg::DATA_W-1:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [dcp_pkg::DATA_W-1:0] avs_readdata,
   output logic avs_waitrequest,
   output logic [NUM_CH-1:0] channel_pulse_output
);

   // ======================================================================
   // elaboration checks
   // ======================================================================
   generate
      if (NUM_CH != dcp_pkg::CH_COUNT) begin : g_bad_ch
         $error("register map serves exactly two channels");
      end
   endgenerate

   // ======================================================================
   // state
   // ======================================================================
   typedef struct packed {
      logic waitreq;
      logic [dcp_pkg::RDATA_W-1:0] rdata;
      logic [NUM_CH-1:0][7:0] width;
      logic [7:0] reload;
      logic [7:0] count;
   } dcp_top_st_t;

   dcp_top_st_t st_ff;
   dcp_top_st_t nxt_st;

   logic tick;
   logic req;
   logic commit_wr;
   logic [7:0] idx;
   logic [7:0] wbyte;
   logic [dcp_pkg::RDATA_W-1:0] rd_mux;
   logic [NUM_CH-1:0] pulse_lvl;

   // ======================================================================
   // bus decode
   // ======================================================================
   // word index from the byte address
   assign idx = avs_address[9:2];
   assign wbyte = avs_writedata[7:0];
   assign req = avs_read | avs_write;
   // write lands on the edge the master sees waitrequest low
   assign commit_wr = ce & avs_write & ~st_ff.waitreq & avs_byteenable[0];

   // read mux, unmapped words read zero
   always_comb begin
      rd_mux = dcp_pkg::RDATA_RST;
      case (idx)
         dcp_pkg::IDX_CH0_WIDTH: begin
            rd_mux[7:0] = st_ff.width[0];
         end
         dcp_pkg::IDX_CH1_WIDTH: begin
            rd_mux[7:0] = st_ff.width[1];
         end
         dcp_pkg::IDX_PRE_RELOAD: begin
            rd_mux[7:0] = st_ff.reload;
         end
         dcp_pkg::IDX_STATUS: begin
            rd_mux[dcp_pkg::STAT_CNT_LSB +: 8] = st_ff.count;
            rd_mux[dcp_pkg::STAT_OUT_LSB +: NUM_CH] = pulse_lvl;
         end
         default: begin
            rd_mux = dcp_pkg::RDATA_RST;
         end
      endcase
   end

   // ======================================================================
   // shared prescaler
   // ======================================================================
   // one tick source for both channels
   dcp_prescaler #(
      .W(8)
   ) u_pre (
      .clk(clk),
      .rst_n(rst_n),
      .ce(ce),
      .reload(st_ff.reload),
      .tick(tick)
   );

   // ======================================================================
   // next state
   // ======================================================================
   // bus handshake, register writes and the shared counter
   always_comb begin
      nxt_st = st_ff;
      if (ce) begin
         // answer one cycle after a request appears
         if (req && st_ff.waitreq) begin
            nxt_st.waitreq = 1'b0;
            if (avs_read) begin
               nxt_st.rdata = rd_mux;
            end
         end else begin
            nxt_st.waitreq = 1'b1;
         end
         // register writes, width acts on the next compare
         if (commit_wr) begin
            case (idx)
               dcp_pkg::IDX_CH0_WIDTH: begin
                  nxt_st.width[0] = wbyte;
               end
               dcp_pkg::IDX_CH1_WIDTH: begin
                  nxt_st.width[1] = wbyte;
               end
               dcp_pkg::IDX_PRE_RELOAD: begin
                  nxt_st.reload = wbyte;
               end
               default: begin
                  nxt_st.reload = st_ff.reload;
               end
            endcase
         end
         // shared counter, modulo 255
         if (tick) begin
            if (st_ff.count == dcp_pkg::CNT_TOP) begin
               nxt_st.count = dcp_pkg::CNT_RST;
            end else begin
               nxt_st.count = st_ff.count + dcp_pkg::CNT_STEP;
            end
         end
      end
   end

   // ======================================================================
   // state register
   // ======================================================================
   // reset clears counter, registers and holds off the bus
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_ff.waitreq <= 1'b1;
         st_ff.rdata <= dcp_pkg::RDATA_RST;
         st_ff.width <= {NUM_CH{dcp_pkg::WIDTH_RST}};
         st_ff.reload <= dcp_pkg::PRE_RST;
         st_ff.count <= dcp_pkg::CNT_RST;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // ======================================================================
   // channels
   // ======================================================================
   // each channel compares its width with the common count
   generate
      for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
         dcp_channel u_ch (
            .clk(clk),
            .rst_n(rst_n),
            .ce(ce),
            .width(st_ff.width[c]),
            .count(st_ff.count),
            .pulse_out(pulse_lvl[c])
         );
      end
   endgenerate

   // ======================================================================
   // outputs
   // ======================================================================
   // all straight from flip-flops
   assign channel_pulse_output = pulse_lvl;
   assign avs_waitrequest = st_ff.waitreq;
   assign avs_readdata = {16'h0000, st_ff.rdata};

   // ======================================================================
   // checks
   // ======================================================================
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   // counter never leaves 0..254
   cnt_range_a: assert property (
      st_ff.count <= dcp_pkg::CNT_TOP)
      else $error("counter above 254");

   // wrap from 254 to 0 on a tick
   cnt_wrap_a: assert property (
      tick && st_ff.count == dcp_pkg::CNT_TOP
      |=> st_ff.count == dcp_pkg::CNT_RST)
      else $error("counter did not wrap at 254");

   // single step on an ordinary tick
   cnt_step_a: assert property (
      tick && st_ff.count != dcp_pkg::CNT_TOP
      |=> st_ff.count == $past(st_ff.count) + dcp_pkg::CNT_STEP)
      else $error("counter did not step by one");

   // counter holds between ticks
   cnt_hold_a: assert property (
      !tick |=> $stable(st_ff.count))
      else $error("counter moved without a tick");

   // ticks never come back to back
   tick_gap_a: assert property (
      tick |=> !tick)
      else $error("prescaler ticked on two adjacent clocks");

   // width ff keeps channel zero low
   full_low_a: assert property (
      ce && st_ff.width[0] == dcp_pkg::WIDTH_ALL_LOW
      |=> !channel_pulse_output[0])
      else $error("width ff did not hold output low");

   // width 00 keeps channel one high
   full_high_a: assert property (
      ce && st_ff.width[1] == dcp_pkg::WIDTH_ALL_HIGH
      |=> channel_pulse_output[1])
      else $error("width 00 did not hold output high");

   // accepted width write lands next clock
   width_write_a: assert property (
      commit_wr && idx == dcp_pkg::IDX_CH0_WIDTH
      |=> st_ff.width[0] == $past(wbyte))
      else $error("width write not applied");

   // reload read returns the stored value
   read_pre_a: assert property (
      ce && avs_read && st_ff.waitreq && idx == dcp_pkg::IDX_PRE_RELOAD
      |=> !avs_waitrequest && avs_readdata[7:0] == $past(st_ff.reload))
      else $error("reload read wrong");

   // every request answered on the next clock when enabled
   bus_answer_a: assert property (
      ce && req && st_ff.waitreq |=> !ce || !avs_waitrequest)
      else $error("request not answered");

   wrap_c: cover property (tick && st_ff.count == dcp_pkg::CNT_TOP);
   ch0_toggle_c: cover property (
      channel_pulse_output[0] ##1 !channel_pulse_output[0]);
   write_c: cover property (commit_wr);
   read_c: cover property (avs_read && !avs_waitrequest);

endmodule : dcp_pwm

// ### dcp_pkg.sv
// ==========================================================================
// shared constants of the dual channel pwm unit
// ==========================================================================
package dcp_pkg;

   // ======================================================================
   // structure
   // ======================================================================
   localparam int unsigned CH_COUNT = 2;
   localparam int unsigned REG_W = 8;
   localparam int unsigned ADDR_W = 10;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned RDATA_W = 16;

   // ======================================================================
   // register indices, byte address is four times the index
   // ======================================================================
   localparam logic [7:0] IDX_CH0_WIDTH = 8'hFC;
   localparam logic [7:0] IDX_CH1_WIDTH = 8'hFD;
   localparam logic [7:0] IDX_PRE_RELOAD = 8'hFE;
   localparam logic [7:0] IDX_STATUS = 8'hFF;

   // ======================================================================
   // status register fields
   // ======================================================================
   localparam int unsigned STAT_CNT_LSB = 0;
   localparam int unsigned STAT_OUT_LSB = 8;

   // ======================================================================
   // reset values and counter limits
   // ======================================================================
   localparam logic [7:0] WIDTH_RST = 8'h00;
   localparam logic [7:0] PRE_RST = 8'h00;
   localparam logic [7:0] CNT_RST = 8'h00;
   localparam logic [7:0] CNT_TOP = 8'hFE;
   localparam logic [7:0] CNT_STEP = 8'h01;
   localparam logic [7:0] WIDTH_ALL_HIGH = 8'h00;
   localparam logic [7:0] WIDTH_ALL_LOW = 8'hFF;
   localparam logic OUT_RST = 1'b1;
   localparam logic [15:0] RDATA_RST = 16'h0000;

endpackage : dcp_pkg

// ### dcp_prescaler.sv
`timescale 1ns/10ps
// ==========================================================================
// fixed divide by two followed by a reloadable down counter
// ==========================================================================
module dcp_prescaler #(
   parameter int unsigned W = 8
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic [W-1:0] reload,
   output logic tick
);

   typedef struct packed {
      logic half;
      logic [W-1:0] cnt;
   } dcp_pre_st_t;

   dcp_pre_st_t st_ff;
   dcp_pre_st_t nxt_st;

   generate
      if (W < 1) begin : g_bad_w
         $error("prescaler width must be at least one");
      end
   endgenerate

   // ======================================================================
   // tick once per 2 x (reload + 1) clocks
   // ======================================================================
   assign tick = ce & st_ff.half & (st_ff.cnt == '0);

   // next state: halve, then count down and reload
   always_comb begin
      nxt_st = st_ff;
      if (ce) begin
         nxt_st.half = ~st_ff.half;
         if (st_ff.half) begin
            if (st_ff.cnt == '0) begin
               nxt_st.cnt = reload;
            end else begin
               nxt_st.cnt = st_ff.cnt - 1'b1;
            end
         end
      end
   end

   // state register, cleared so counting restarts from zero
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // ======================================================================
   // checks
   // ======================================================================
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   tick_half_a: assert property (tick |-> st_ff.half)
      else $error("tick outside second half clock");
   tick_reload_a: assert property (tick |=> st_ff.cnt == $past(reload))
      else $error("prescaler did not reload");

endmodule : dcp_prescaler

// ### dcp_channel.sv
`timescale 1ns/10ps
// ==========================================================================
// one compare channel with a registered output level
// ==========================================================================
module dcp_channel (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic [7:0] width,
   input wire logic [7:0] count,
   output logic pulse_out
);

   typedef struct packed {
      logic level;
   } dcp_ch_st_t;

   dcp_ch_st_t st_ff;
   dcp_ch_st_t nxt_st;

   // low while width exceeds count, high otherwise
   always_comb begin
      nxt_st = st_ff;
      if (ce) begin
         nxt_st.level = !(width > count);
      end
   end

   // output register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_ff <= '{level: dcp_pkg::OUT_RST};
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign pulse_out = st_ff.level;

   // ======================================================================
   // checks
   // ======================================================================
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   out_low_a: assert property (ce && width > count |=> !pulse_out)
      else $error("output not low while width above count");
   out_high_a: assert property (ce && width <= count |=> pulse_out)
      else $error("output not high while width at or below count");

endmodule : dcp_channel

// ### dcp_filter_model.sv
`timescale 1ns/10ps
// ==========================================================================
// integrating load: counts low clocks and rising edges of each channel
// ==========================================================================
module dcp_filter_model (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic clear,
   input wire logic [1:0] pwm_in,
   output logic [1:0][15:0] low_cnt,
   output logic [1:0][15:0] rise_cnt
);
   logic [1:0] prev_ff;

   // integrate once per clock, clear opens a new window
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         low_cnt <= '0;
         rise_cnt <= '0;
         prev_ff <= 2'h3;
      end else begin
         prev_ff <= pwm_in;
         for (int i = 0; i < 2; i++) begin
            if (clear) begin
               low_cnt[i] <= 16'h0000;
               rise_cnt[i] <= 16'h0000;
            end else begin
               low_cnt[i] <= low_cnt[i] + {15'h0000, ~pwm_in[i]};
               rise_cnt[i] <= rise_cnt[i] + {15'h0000, pwm_in[i] & ~prev_ff[i]};
            end
         end
      end
   end
endmodule : dcp_filter_model

// ### tb.sv
`timescale 1ns/10ps
// ==========================================================================
// self-checking bench of the dual channel pwm unit
// ==========================================================================
module tb;
   logic clk = 1'b0;
   logic rst_n, ce, avs_read, avs_write, clear;
   logic [9:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata;
   logic [3:0] avs_byteenable;
   logic avs_waitrequest;
   logic [1:0] pwm;
   logic [1:0][15:0] low_cnt, rise_cnt;
   logic [31:0] st;
   int mismatches = 0;
   int total_checks = 0;

   // 40 MHz clock
   always #12.5 clk = ~clk;

   dcp_pwm dut_u (.clk(clk), .rst_n(rst_n), .ce(ce),
      .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .channel_pulse_output(pwm));

   dcp_filter_model load_u (.clk(clk), .rst_n(rst_n), .clear(clear),
      .pwm_in(pwm), .low_cnt(low_cnt), .rise_cnt(rise_cnt));

   // ======================================================================
   // reporting
   // ======================================================================
   task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                        input string what);
      total_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] %0t %s seen %h exp %h", $time, what, seen, exp);
      end
   endtask : check

   task automatic conclude();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : conclude

   // ======================================================================
   // avalon-mm master
   // ======================================================================
   task automatic bus(input logic is_wr, input logic [7:0] idx,
                      input logic [7:0] data, input logic [3:0] bytes,
                      output logic [31:0] got);
      int n;
      @(posedge clk);
      avs_address <= {idx, 2'h0};
      avs_write <= is_wr;
      avs_read <= !is_wr;
      avs_writedata <= {24'h000000, data};
      avs_byteenable <= bytes;
      for (n = 0; n < 100; n++) begin
         @(posedge clk);
         if (avs_waitrequest === 1'b0) break;
      end
      got = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      if (n == 100) begin
         mismatches++;
         conclude();
      end
   endtask : bus

   task automatic wr(input logic [7:0] idx, input logic [7:0] data);
      logic [31:0] got;
      bus(1'b1, idx, data, 4'h1, got);
   endtask : wr

   task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
      logic [31:0] got;
      bus(1'b0, idx, 8'h00, 4'hF, got);
      check(got, exp, "read data");
   endtask : rd

   // one full period of both channels through the load model
   task automatic measure(input logic [7:0] w0, input logic [7:0] w1,
                          input logic [7:0] rl);
      int per;
      logic [7:0] w [2];
      per = 2 * (int'(rl) + 1) * 255;
      w[0] = w0;
      w[1] = w1;
      wr(dcp_pkg::IDX_PRE_RELOAD, rl);
      wr(dcp_pkg::IDX_CH0_WIDTH, w0);
      wr(dcp_pkg::IDX_CH1_WIDTH, w1);
      repeat (20) @(posedge clk);
      clear <= 1'b1;
      @(posedge clk);
      clear <= 1'b0;
      repeat (per + 1) @(posedge clk);
      for (int i = 0; i < 2; i++) begin
         check({16'h0000, low_cnt[i]}, 32'(2 * (int'(rl) + 1) * int'(w[i])), "low time");
         check({16'h0000, rise_cnt[i]}, (w[i] == 8'h00 || w[i] == 8'hFF) ? 32'h0 : 32'h1, "pulses");
      end
   endtask : measure

   // ======================================================================
   // main sequence
   // ======================================================================
   initial begin
      rst_n = 1'b0;
      ce = 1'b1;
      avs_address = 10'h000;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h00000000;
      avs_byteenable = 4'h0;
      clear = 1'b0;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      rd(dcp_pkg::IDX_CH0_WIDTH, 32'h0);
      rd(dcp_pkg::IDX_CH1_WIDTH, 32'h0);
      rd(dcp_pkg::IDX_PRE_RELOAD, 32'h0);
      check({30'h0, pwm}, 32'h3, "outputs after reset");
      // readback of all three writable registers, back to back
      for (int i = 0; i < 3; i++) begin
         wr(8'hFC + 8'(i), 8'hA5 ^ 8'(i));
         rd(8'hFC + 8'(i), {24'h0, 8'hA5 ^ 8'(i)});
      end
      // disabled byte lane and unmapped index are ignored
      bus(1'b1, dcp_pkg::IDX_CH0_WIDTH, 8'h5A, 4'hE, st);
      rd(dcp_pkg::IDX_CH0_WIDTH, 32'hA5);
      wr(8'h10, 8'h77);
      rd(8'h10, 32'h0);
      // counter never passes 254 over 200 status reads, 600 clocks, more than one 510 clock period
      wr(dcp_pkg::IDX_PRE_RELOAD, 8'h00);
      for (int i = 0; i < 200; i++) begin
         bus(1'b0, dcp_pkg::IDX_STATUS, 8'h00, 4'hF, st);
         check({31'h0, st[7:0] > 8'hFE}, 32'h0, "counter range");
      end
      measure(8'h03, 8'hC8, 8'h00);
      measure(8'h00, 8'hFF, 8'h00);
      measure(8'h01, 8'hFE, 8'h01);
      measure(8'h80, 8'h7F, 8'h02);
      // new width acts long before the 2040 clock period ends
      wr(dcp_pkg::IDX_PRE_RELOAD, 8'h03);
      wr(dcp_pkg::IDX_CH0_WIDTH, 8'h00);
      repeat (2) @(posedge clk);
      check({31'h0, pwm[0]}, 32'h1, "width 00 high");
      wr(dcp_pkg::IDX_CH0_WIDTH, 8'hFF);
      repeat (2) @(posedge clk);
      check({31'h0, pwm[0]}, 32'h0, "immediate width");
      // reset in mid-run restarts the waveform
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      check({30'h0, pwm}, 32'h3, "outputs in reset");
      check({31'h0, avs_waitrequest}, 32'h1, "wait in reset");
      rst_n <= 1'b1;
      bus(1'b0, dcp_pkg::IDX_STATUS, 8'h00, 4'hF, st);
      check({31'h0, st[7:0] < 8'h08}, 32'h1, "counter restart");
      rd(dcp_pkg::IDX_PRE_RELOAD, 32'h0);
      conclude();
   end

   // watchdog against a hang anywhere
   initial begin
      repeat (100000) @(posedge clk);
      mismatches++;
      conclude();
   end
endmodule : tb
